// File: bench/jtag_tap_controller_test.sv
// self-checking bench: tester end and device end joined across the test link
module jtag_tap_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LW = $clog2(64 + 1);
  logic                  clk          = 1'b0;
  logic                  srst         = 1'b1;
  logic                  test_en      = 1'b1;
  logic                  cmd_valid    = 1'b0;
  jtp_pkg::jtp_kind_type cmd_kind     = jtp_pkg::KIND_RESET;
  logic [LW-1:0]         cmd_len      = '0;
  logic [63:0]           cmd_data     = '0;
  logic [7:0]            core_out     = 8'h00;
  logic [7:0]            core_oe      = 8'h00;
  logic [7:0]            pad_in       = 8'h00;
  logic                  cmd_ready;
  logic                  rsp_valid;
  logic [63:0]           rsp_data;
  logic [7:0]            pad_out;
  logic [7:0]            pad_oe;
  logic [7:0]            core_in;
  logic                  tap_in_reset;
  logic [63:0]           rsp;
  logic [63:0]           d;
  logic [63:0]           upd;
  logic [27:0]           ops [5];
  int                    n_errors        = 0;
  int                    samples_checked = 0;
  int                    cycles          = 0;
  jtp_if link ();
  jtp_tap_dev #(.NOUT(8), .NIN(8), .VERSION(0)) u_jtp_tap_dev (
    .clk          (clk),
    .srst         (srst),
    .jtag         (link.dev),
    .core_out     (core_out),
    .core_oe      (core_oe),
    .pad_in       (pad_in),
    .pad_out      (pad_out),
    .pad_oe       (pad_oe),
    .core_in      (core_in),
    .tap_in_reset (tap_in_reset)
  );
  jtp_tap_host u_jtp_tap_host (
    .clk       (clk),
    .srst      (srst),
    .jtag      (link.host),
    .test_en   (test_en),
    .cmd_valid (cmd_valid),
    .cmd_ready (cmd_ready),
    .cmd_kind  (cmd_kind),
    .cmd_len   (cmd_len),
    .cmd_data  (cmd_data),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data)
  );
  jtp_link_props u_props (
    .clk      (clk),
    .srst     (srst),
    .tck      (link.tck),
    .tms      (link.tms),
    .tdi      (link.tdi),
    .test_sel (link.test_sel),
    .tdo      (link.tdo),
    .tdo_oe   (link.tdo_oe)
  );
  always #4 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results;
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // about twenty scans of at most some 620 cycles each, so this leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors = n_errors + 1;
      results();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hold the request until ready is sampled high, then wait for the answer
  task automatic run(input jtp_pkg::jtp_kind_type k, input int len, input logic [63:0] data);
    cmd_kind = k;
    cmd_len = LW'(len);
    cmd_data = data;
    cmd_valid = 1'b1;
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    #1 cmd_valid = 1'b0;
    @(posedge clk);
    while ((k == jtp_pkg::KIND_RESET) ? (cmd_ready !== 1'b1) : (rsp_valid !== 1'b1)) @(posedge clk);
    rsp = rsp_data;
    #1;
  endtask
  function automatic logic [7:0] exp_oe(input logic [27:0] op);
    if (op == jtp_pkg::OP_CLAMP || op == jtp_pkg::OP_EXTEST) return 8'hFF;
    if (op == jtp_pkg::OP_HIGHZ) return 8'h00;
    return core_oe;
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hB144));
    core_out = 8'($urandom());
    core_oe = 8'($urandom());
    pad_in = 8'($urandom());
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    check(tap_in_reset, 1'b1);
    run(jtp_pkg::KIND_RESET, 0, 64'h0);
    run(jtp_pkg::KIND_DR, 32, 64'($urandom()));
    check(rsp[31:0], jtp_pkg::ID_V0);
    run(jtp_pkg::KIND_IR, 28, 64'(jtp_pkg::OP_SAMPLE));
    check(rsp[27:0], jtp_pkg::IR_CAPTURE);
    d = 64'($urandom());
    run(jtp_pkg::KIND_DR, 16, d);
    check(rsp[15:0], {pad_in, core_out});
    check({pad_out, pad_oe, core_in}, {core_out, core_oe, pad_in});
    upd = d;
    run(jtp_pkg::KIND_IR, 28, 64'(jtp_pkg::OP_EXTEST));
    check({pad_out, pad_oe}, {upd[7:0], 8'hFF});
    d = 64'($urandom());
    run(jtp_pkg::KIND_DR, 16, d);
    check(rsp[15:0], {pad_in, upd[7:0]});
    upd = d;
    check(pad_out, upd[7:0]);
    // last entry is an undefined code, which must fall back to bypass
    ops = '{jtp_pkg::OP_BYP0, jtp_pkg::OP_BYP1, jtp_pkg::OP_CLAMP, jtp_pkg::OP_HIGHZ, {4'hA, 24'($urandom())}};
    foreach (ops[j]) begin
      run(jtp_pkg::KIND_IR, 28, 64'(ops[j]));
      check(rsp[27:0], jtp_pkg::IR_CAPTURE);
      check(pad_oe, exp_oe(ops[j]));
      if (ops[j] == jtp_pkg::OP_CLAMP) check(pad_out, upd[7:0]);
      d = 64'($urandom());
      run(jtp_pkg::KIND_DR, 8, d);
      check(rsp[7:0], {d[6:0], 1'b0});
    end
    run(jtp_pkg::KIND_RESET, 0, 64'h0);
    check(pad_oe, core_oe);
    run(jtp_pkg::KIND_DR, 32, ~64'h0);
    check(rsp[31:0], jtp_pkg::ID_V0);
    // with select low the scan must be ignored and the line reads pulled up
    test_en = 1'b0;
    run(jtp_pkg::KIND_IR, 28, 64'(jtp_pkg::OP_EXTEST));
    check({tap_in_reset, link.tdo_oe, rsp[27:0]}, {1'b1, 1'b0, 28'hFFFFFFF});
    check(pad_oe, core_oe);
    test_en = 1'b1;
    run(jtp_pkg::KIND_RESET, 0, 64'h0);
    run(jtp_pkg::KIND_DR, 32, 64'($urandom()));
    check(rsp[31:0], jtp_pkg::ID_V0);
    results();
  end
endmodule

// File: bench/jtp_link_props.sv
// timing checks on the four-wire test link between tester and device
module jtp_link_props (
  input wire logic clk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic test_sel,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // clock phases
  // ----------------------------------------
  sequence s_tck_up;  $rose(tck); endsequence
  sequence s_tck_dn;  $fell(tck); endsequence
  sequence s_hold_hi; tck [*8];   endsequence
  sequence s_hold_lo; !tck [*8];  endsequence
  chk_tck_high_min: assert property (s_tck_up |-> s_hold_hi)
    else $error("test clock high phase too short");
  chk_tck_low_min: assert property (s_tck_dn |-> s_hold_lo)
    else $error("test clock low phase too short");
  chk_tck_period: assert property (s_tck_up |-> ##16 $rose(tck))
    else $error("test clock period wrong");
  // ----------------------------------------
  // launch and capture edges
  // ----------------------------------------
  // mode select and data in move only in the low phase, so they are stable at the rise
  chk_tms_off_rise: assert property ($changed(tms) |-> !tck)
    else $error("mode select moved while clock high");
  chk_tdi_off_rise: assert property ($changed(tdi) |-> !tck)
    else $error("data in moved while clock high");
  chk_tdo_on_fall: assert property ($changed(tdo) && test_sel |-> !tck && !$past(tck, 2))
    else $error("data out moved outside the low phase");
  // the enable is launched with data out, so it too moves only in the low phase
  chk_oe_on_fall: assert property ($changed(tdo_oe) && test_sel |-> !tck && !$past(tck, 2))
    else $error("data out enable moved outside the low phase");
  chk_sel_gates_oe: assert property (!test_sel [*6] |-> !tdo_oe)
    else $error("data out driven without test select");
endmodule

// File: inc/jtp_if.sv
// four-wire serial test link with test select
interface jtp_if;
  logic tck;
  logic tms;
  logic tdi;
  logic test_sel;
  logic tdo;
  logic tdo_oe;
  wire  tdo_line;
  // undriven output reads high, as a pulled-up line would
  assign tdo_line = tdo_oe ? tdo : 1'b1;
  modport dev  (input tck, input tms, input tdi, input test_sel, output tdo, output tdo_oe);
  modport host (output tck, output tms, output tdi, output test_sel, input tdo_line);
endinterface

// File: inc/jtp_pkg.sv
// shared constants and types for the test access port and its tester
package jtp_pkg;
  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  localparam int        IR_W       = 28;
  localparam logic [27:0] OP_BYP0    = 28'h000000;
  localparam logic [27:0] OP_BYP1    = 28'hFFFFFF;
  localparam logic [27:0] OP_SAMPLE  = 28'hFFFFF8;
  localparam logic [27:0] OP_EXTEST  = 28'hFFFFE8;
  localparam logic [27:0] OP_CLAMP   = 28'hFFFFEF;
  localparam logic [27:0] OP_IDCODE  = 28'hFFFFFE;
  localparam logic [27:0] OP_HIGHZ   = 28'hFFFFCF;
  localparam logic [27:0] IR_CAPTURE = 28'h0000001;
  // ----------------------------------------
  // identification (values are arbitrary)
  // ----------------------------------------
  localparam int          ID_W   = 32;
  localparam logic [31:0] ID_V0  = 32'h0A5C0001;
  localparam logic [31:0] ID_V1  = 32'h0A5C1001;
  // ----------------------------------------
  // tester timing and header patterns
  // ----------------------------------------
  localparam int          TCK_HALF_DEF = 8;
  localparam int          TCK_HALF_MIN = 8;
  localparam logic [4:0]  HEAD_RESET   = 5'h1F;
  localparam logic [2:0]  HEAD_RESET_N = 3'h5;
  localparam logic [4:0]  HEAD_IR      = 5'h03;
  localparam logic [2:0]  HEAD_IR_N    = 3'h4;
  localparam logic [4:0]  HEAD_DR      = 5'h01;
  localparam logic [2:0]  HEAD_DR_N    = 3'h3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHF_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHF_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } jtp_tap_type;
  typedef enum logic [1:0] {KIND_RESET, KIND_IR, KIND_DR} jtp_kind_type;
endpackage

// File: rtl/jtp_sync.sv
// two-stage synchroniser for a group of pins
module jtp_sync #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         srst,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule

// File: rtl/jtp_tap_dev.sv
// test access port of the device: state machine, instruction and data registers
// Operation
// - standard tap machine, instruction and data registers
// - exactly four serial test signals
// - all transfers follow the test clock only
// - mode select and data in sampled rising
// - data out changes on falling test clock
// - scan active only while test select asserted
// - all-zeros instruction selects bypass register
// - all-ones instruction also selects bypass
// - sample/preload captures pins, shifts without disturbing
// - extest drives outputs from boundary register
// - clamp holds outputs, bypass selected
// - highz floats outputs, bypass selected
// - idcode selects 32-bit identification register
// - identification differs between two versions
module jtp_tap_dev #(
  parameter int NOUT    = 8,
  parameter int NIN     = 8,
  parameter int VERSION = 0
) (
  input  logic            clk,
  input  logic            srst,
  jtp_if.dev              jtag,
  input  logic [NOUT-1:0] core_out,
  input  logic [NOUT-1:0] core_oe,
  input  logic [NIN-1:0]  pad_in,
  output logic [NOUT-1:0] pad_out,
  output logic [NOUT-1:0] pad_oe,
  output logic [NIN-1:0]  core_in,
  output logic            tap_in_reset
);
  localparam int BSR_W = NOUT + NIN;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (NOUT < 1 || NIN < 1) begin : g_chk_w
    $error("jtp_tap_dev: NOUT and NIN must be at least 1");
  end
  if (VERSION != 0 && VERSION != 1) begin : g_chk_v
    $error("jtp_tap_dev: VERSION must be 0 or 1");
  end

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic [3:0] pins_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       sel_s;
  logic       tck_d_r;
  logic       rise;
  logic       fall;

  // the three test inputs plus select travel together so they stay aligned
  jtp_sync #(.W(4)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    ({jtag.test_sel, jtag.tdi, jtag.tms, jtag.tck}),
    .q    (pins_s)
  );
  assign tck_s = pins_s[0];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[2];
  assign sel_s = pins_s[3];

  always_ff @(posedge clk) begin
    if (srst) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end
  // every step is keyed to test clock edges, not to the core's clocks
  assign rise = tck_s & ~tck_d_r;
  assign fall = ~tck_s & tck_d_r;

  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  jtp_pkg::jtp_tap_type tap_r;
  jtp_pkg::jtp_tap_type tap_nxt;
  logic                 tap_kill;

  // standard transition table; five highs reach reset from anywhere
  always_comb begin
    tap_nxt = tap_r;
    case (tap_r)
      jtp_pkg::TAP_RESET:  tap_nxt = tms_s ? jtp_pkg::TAP_RESET  : jtp_pkg::TAP_IDLE;
      jtp_pkg::TAP_IDLE:   tap_nxt = tms_s ? jtp_pkg::TAP_SEL_DR : jtp_pkg::TAP_IDLE;
      jtp_pkg::TAP_SEL_DR: tap_nxt = tms_s ? jtp_pkg::TAP_SEL_IR : jtp_pkg::TAP_CAP_DR;
      jtp_pkg::TAP_CAP_DR: tap_nxt = tms_s ? jtp_pkg::TAP_EX1_DR : jtp_pkg::TAP_SHF_DR;
      jtp_pkg::TAP_SHF_DR: tap_nxt = tms_s ? jtp_pkg::TAP_EX1_DR : jtp_pkg::TAP_SHF_DR;
      jtp_pkg::TAP_EX1_DR: tap_nxt = tms_s ? jtp_pkg::TAP_UPD_DR : jtp_pkg::TAP_PAU_DR;
      jtp_pkg::TAP_PAU_DR: tap_nxt = tms_s ? jtp_pkg::TAP_EX2_DR : jtp_pkg::TAP_PAU_DR;
      jtp_pkg::TAP_EX2_DR: tap_nxt = tms_s ? jtp_pkg::TAP_UPD_DR : jtp_pkg::TAP_SHF_DR;
      jtp_pkg::TAP_UPD_DR: tap_nxt = tms_s ? jtp_pkg::TAP_SEL_DR : jtp_pkg::TAP_IDLE;
      jtp_pkg::TAP_SEL_IR: tap_nxt = tms_s ? jtp_pkg::TAP_RESET  : jtp_pkg::TAP_CAP_IR;
      jtp_pkg::TAP_CAP_IR: tap_nxt = tms_s ? jtp_pkg::TAP_EX1_IR : jtp_pkg::TAP_SHF_IR;
      jtp_pkg::TAP_SHF_IR: tap_nxt = tms_s ? jtp_pkg::TAP_EX1_IR : jtp_pkg::TAP_SHF_IR;
      jtp_pkg::TAP_EX1_IR: tap_nxt = tms_s ? jtp_pkg::TAP_UPD_IR : jtp_pkg::TAP_PAU_IR;
      jtp_pkg::TAP_PAU_IR: tap_nxt = tms_s ? jtp_pkg::TAP_EX2_IR : jtp_pkg::TAP_PAU_IR;
      jtp_pkg::TAP_EX2_IR: tap_nxt = tms_s ? jtp_pkg::TAP_UPD_IR : jtp_pkg::TAP_SHF_IR;
      jtp_pkg::TAP_UPD_IR: tap_nxt = tms_s ? jtp_pkg::TAP_SEL_DR : jtp_pkg::TAP_IDLE;
      default:             tap_nxt = jtp_pkg::TAP_RESET;
    endcase
  end

  // select low parks the port in reset, so nothing scans
  assign tap_kill = srst | ~sel_s;

  always_ff @(posedge clk) begin
    if (tap_kill) begin
      tap_r <= jtp_pkg::TAP_RESET;
    end else if (rise) begin
      tap_r <= tap_nxt;
    end
  end

  // ----------------------------------------
  // instruction register and decode
  // ----------------------------------------
  logic [jtp_pkg::IR_W-1:0] ir_r;
  logic [jtp_pkg::IR_W-1:0] ir_sh_r;
  logic                     op_sample;
  logic                     op_extest;
  logic                     op_clamp;
  logic                     op_highz;
  logic                     op_idcode;
  logic                     op_bsr;
  logic                     op_bypass;

  always_ff @(posedge clk) begin
    if (tap_kill || tap_r == jtp_pkg::TAP_RESET) begin
      ir_r    <= jtp_pkg::OP_IDCODE;
      ir_sh_r <= jtp_pkg::IR_CAPTURE;
    end else if (rise) begin
      if (tap_r == jtp_pkg::TAP_CAP_IR) begin
        ir_sh_r <= jtp_pkg::IR_CAPTURE;
      end else if (tap_r == jtp_pkg::TAP_SHF_IR) begin
        ir_sh_r <= {tdi_s, ir_sh_r[jtp_pkg::IR_W-1:1]};
      end else if (tap_r == jtp_pkg::TAP_UPD_IR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  assign op_sample = (ir_r == jtp_pkg::OP_SAMPLE);
  assign op_extest = (ir_r == jtp_pkg::OP_EXTEST);
  assign op_clamp  = (ir_r == jtp_pkg::OP_CLAMP);
  assign op_highz  = (ir_r == jtp_pkg::OP_HIGHZ);
  assign op_idcode = (ir_r == jtp_pkg::OP_IDCODE);
  assign op_bsr    = op_sample | op_extest;
  // both bypass codes, clamp, highz and any unknown code land on bypass
  assign op_bypass = ~op_bsr & ~op_idcode;

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  localparam logic [31:0] ID_VAL = (VERSION == 0) ? jtp_pkg::ID_V0 : jtp_pkg::ID_V1;

  logic                      byp_r;
  logic [jtp_pkg::ID_W-1:0]  id_sh_r;
  logic [BSR_W-1:0]          bsr_sh_r;
  logic [BSR_W-1:0]          bsr_upd_r;

  // inputs sit in the high cells, outputs in the low cells
  always_ff @(posedge clk) begin
    if (srst) begin
      byp_r     <= 1'b0;
      id_sh_r   <= '0;
      bsr_sh_r  <= '0;
      bsr_upd_r <= '0;
    end else if (rise) begin
      if (tap_r == jtp_pkg::TAP_CAP_DR) begin
        byp_r    <= 1'b0;
        id_sh_r  <= ID_VAL;
        bsr_sh_r <= op_bsr ? {pad_in, pad_out} : bsr_sh_r;
      end else if (tap_r == jtp_pkg::TAP_SHF_DR) begin
        byp_r    <= op_bypass ? tdi_s : byp_r;
        id_sh_r  <= op_idcode ? {tdi_s, id_sh_r[jtp_pkg::ID_W-1:1]} : id_sh_r;
        bsr_sh_r <= op_bsr ? {tdi_s, bsr_sh_r[BSR_W-1:1]} : bsr_sh_r;
      end else if (tap_r == jtp_pkg::TAP_UPD_DR && op_bsr) begin
        bsr_upd_r <= bsr_sh_r; // preload under sample, live under extest
      end
    end
  end

  // ----------------------------------------
  // serial output, changed on the falling edge
  // ----------------------------------------
  logic tdo_r;
  logic tdo_oe_r;
  logic dr_bit;

  assign dr_bit = op_idcode ? id_sh_r[0] : (op_bsr ? bsr_sh_r[0] : byp_r);

  always_ff @(posedge clk) begin
    if (tap_kill) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (fall) begin
      tdo_r    <= (tap_r == jtp_pkg::TAP_SHF_IR) ? ir_sh_r[0] : dr_bit;
      tdo_oe_r <= (tap_r == jtp_pkg::TAP_SHF_IR) || (tap_r == jtp_pkg::TAP_SHF_DR);
    end
  end
  assign jtag.tdo    = tdo_r;
  assign jtag.tdo_oe = tdo_oe_r;

  // ----------------------------------------
  // pad control
  // ----------------------------------------
  logic              bsr_drive;
  logic [NOUT-1:0]   pad_out_nxt;
  logic [NOUT-1:0]   pad_oe_nxt;
  logic [NOUT-1:0]   pad_out_r;
  logic [NOUT-1:0]   pad_oe_r;
  logic [NIN-1:0]    core_in_r;

  // clamp shares extest's drive but leaves bypass on the chain
  assign bsr_drive   = op_extest | op_clamp;
  assign pad_out_nxt = bsr_drive ? bsr_upd_r[NOUT-1:0] : core_out;
  // highz floats every output; extest/clamp enable all output cells
  assign pad_oe_nxt  = op_highz ? '0 : (bsr_drive ? '1 : core_oe);

  always_ff @(posedge clk) begin
    if (srst) begin
      pad_out_r <= '0;
      pad_oe_r  <= '0;
      core_in_r <= '0;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r  <= pad_oe_nxt;
      core_in_r <= pad_in; // sample keeps the core path untouched
    end
  end

  assign pad_out      = pad_out_r;
  assign pad_oe       = pad_oe_r;
  assign core_in      = core_in_r;
  assign tap_in_reset = (tap_r == jtp_pkg::TAP_RESET);
endmodule

// File: rtl/jtp_tap_host.sv
// tester end: makes the test clock and walks reset, instruction and data scans
module jtp_tap_host #(
  parameter int MAXLEN   = 64,
  parameter int TCK_HALF = jtp_pkg::TCK_HALF_DEF,
  parameter int LENW     = $clog2(MAXLEN + 1)
) (
  input  logic                 clk,
  input  logic                 srst,
  jtp_if.host                  jtag,
  input  logic                 test_en,
  input  logic                 cmd_valid,
  output logic                 cmd_ready,
  input  jtp_pkg::jtp_kind_type cmd_kind,
  input  logic [LENW-1:0]      cmd_len,
  input  logic [MAXLEN-1:0]    cmd_data,
  output logic                 rsp_valid,
  output logic [MAXLEN-1:0]    rsp_data
);
  if (MAXLEN < jtp_pkg::ID_W || MAXLEN < jtp_pkg::IR_W || TCK_HALF < jtp_pkg::TCK_HALF_MIN) begin : g_chk
    $error("jtp_tap_host: MAXLEN too small or TCK_HALF below minimum");
  end

  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_HEAD, H_SHIFT, H_TAIL} jtp_hst_type;

  // ----------------------------------------
  // clock divider
  // ----------------------------------------
  logic [7:0] div_r;
  logic       tck_r;
  logic       tick;
  logic       rise_ev;
  logic       fall_ev;

  assign tick    = (div_r == 8'(TCK_HALF - 1));
  assign rise_ev = tick & ~tck_r;
  assign fall_ev = tick & tck_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      div_r <= '0;
      tck_r <= 1'b0;
    end else begin
      div_r <= tick ? '0 : div_r + 8'h01;
      tck_r <= tick ? ~tck_r : tck_r;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  logic                    tdo_s;
  jtp_hst_type             st_r;
  jtp_pkg::jtp_kind_type   kind_r;
  logic [4:0]              head_r;
  logic [2:0]              hcnt_r;
  logic [LENW-1:0]         len_r;
  logic [LENW-1:0]         scnt_r;
  logic [MAXLEN-1:0]       dat_r;
  logic [MAXLEN-1:0]       cap_r;
  logic                    tail_r;
  logic                    tms_r;
  logic                    tdi_r;
  logic                    sel_r;
  logic                    rsp_valid_r;
  logic [MAXLEN-1:0]       rsp_r;
  logic [LENW-1:0]         len_eff;
  logic [LENW-1:0]         rsp_shift;

  jtp_sync #(.W(1)) u_sync (
    .clk  (clk),
    .srst (srst),
    .d    (jtag.tdo_line),
    .q    (tdo_s)
  );

  // zero length is served as one bit
  assign len_eff   = (cmd_len == '0) ? LENW'(1) : cmd_len;
  assign rsp_shift = LENW'(MAXLEN) - len_r;
  assign cmd_ready = (st_r == H_IDLE);

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r        <= H_IDLE;
      kind_r      <= jtp_pkg::KIND_RESET;
      head_r      <= '0;
      hcnt_r      <= '0;
      len_r       <= LENW'(1);
      scnt_r      <= '0;
      dat_r       <= '0;
      cap_r       <= '0;
      tail_r      <= 1'b0;
      tms_r       <= 1'b0;
      tdi_r       <= 1'b0;
      sel_r       <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      sel_r       <= test_en; // select follows test_en one cycle later, also during an access
      rsp_valid_r <= 1'b0;
      if (rise_ev && st_r == H_SHIFT) begin
        cap_r <= {tdo_s, cap_r[MAXLEN-1:1]}; // sampled on the rising edge
      end
      if (st_r == H_IDLE && cmd_valid) begin
        st_r   <= H_WAIT;
        kind_r <= cmd_kind;
        len_r  <= len_eff;
        scnt_r <= len_eff - LENW'(1);
        dat_r  <= cmd_data;
        head_r <= (cmd_kind == jtp_pkg::KIND_RESET) ? jtp_pkg::HEAD_RESET :
                  (cmd_kind == jtp_pkg::KIND_IR) ? jtp_pkg::HEAD_IR : jtp_pkg::HEAD_DR;
        hcnt_r <= (cmd_kind == jtp_pkg::KIND_RESET) ? jtp_pkg::HEAD_RESET_N :
                  (cmd_kind == jtp_pkg::KIND_IR) ? jtp_pkg::HEAD_IR_N : jtp_pkg::HEAD_DR_N;
      end else if (fall_ev) begin
        // new levels are set on the falling edge, stable around the rising one
        case (st_r)
          H_WAIT: begin
            st_r   <= H_HEAD;
            tms_r  <= head_r[0];
            head_r <= {1'b0, head_r[4:1]};
            hcnt_r <= hcnt_r - 3'h1;
          end
          H_HEAD: begin
            if (hcnt_r != 3'h0) begin
              tms_r  <= head_r[0];
              head_r <= {1'b0, head_r[4:1]};
              hcnt_r <= hcnt_r - 3'h1;
            end else if (kind_r == jtp_pkg::KIND_RESET) begin
              st_r   <= H_TAIL; // five highs done, one low into idle
              tail_r <= 1'b0;
              tms_r  <= 1'b0;
            end else begin
              st_r  <= H_SHIFT;
              tms_r <= (scnt_r == '0);
              tdi_r <= dat_r[0];
              dat_r <= {1'b0, dat_r[MAXLEN-1:1]};
            end
          end
          H_SHIFT: begin
            if (scnt_r == '0) begin
              st_r   <= H_TAIL;
              tail_r <= 1'b1;
              tms_r  <= 1'b1;
              tdi_r  <= 1'b0;
            end else begin
              scnt_r <= scnt_r - LENW'(1);
              tms_r  <= (scnt_r == LENW'(1));
              tdi_r  <= dat_r[0];
              dat_r  <= {1'b0, dat_r[MAXLEN-1:1]};
            end
          end
          H_TAIL: begin
            tms_r <= 1'b0;
            if (tail_r) begin
              tail_r <= 1'b0;
            end else begin
              st_r        <= H_IDLE;
              rsp_valid_r <= (kind_r != jtp_pkg::KIND_RESET);
              rsp_r       <= cap_r >> rsp_shift;
            end
          end
          default: begin
            tms_r <= 1'b0;
            tdi_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign jtag.tck      = tck_r;
  assign jtag.tms      = tms_r;
  assign jtag.tdi      = tdi_r;
  assign jtag.test_sel = sel_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_data      = rsp_r;
endmodule
